// ### logic/abds_defines.svh
// Register map, field positions, reset values and character codes of the digit store
`ifndef ABDS_DEFINES_SVH
`define ABDS_DEFINES_SVH

`define ABDS_ADR_CTRL 8'h00
`define ABDS_ADR_POL_LO 8'h04
`define ABDS_ADR_POL_HI 8'h08
`define ABDS_ADR_STATUS 8'h0C
`define ABDS_ADR_CMD 8'h10
`define ABDS_ADR_DIG_LO 8'h14
`define ABDS_ADR_DIG_HI 8'h18

`define ABDS_CTRL_MODE_BIT 0
`define ABDS_CTRL_PRESET_LSB 4
`define ABDS_CTRL_RST 32'h0000_0000
`define ABDS_POL_LO_RST 32'h0000_0000
`define ABDS_POL_HI_RST 8'h00

`define ABDS_CMD_PRINT_RESET_BIT 0
`define ABDS_CMD_PRECODE_BIT 1

`define ABDS_STAT_FULL_BIT 4
`define ABDS_STAT_INVALID_BIT 5
`define ABDS_STAT_STROBE_BIT 6

`define ABDS_ASC_ZERO 7'h30
`define ABDS_ASC_NINE 7'h39
`define ABDS_ASC_LTR_B 7'h42
`define ABDS_ASC_LTR_G 7'h47
`define ABDS_ASC_LTR_E 7'h45
`define ABDS_ASC_SPACE 7'h20
`define ABDS_ASC_MINUS 7'h2D
`define ABDS_LTR_OFFSET 7'h38

`define ABDS_BCD_SPACE 4'hA
`define ABDS_BCD_E 4'hF
`define ABDS_BCD_MINUS 4'hB

`define ABDS_LAST_DIGIT 4'h9

`endif

// ### logic/abds_pkg.sv
// Types shared by the ASCII to BCD digit store
package abds_pkg;

  typedef enum logic
  {
    ABDS_PROGRAM_MODE = 1'b0,
    ABDS_RECORD_MODE = 1'b1
  } abds_mode_t;

  typedef logic [3:0] abds_nibble_t;

endpackage : abds_pkg

// ### logic/abds_storage.sv
// ASCII to BCD digit store: encoder, digit position counter, ten digit latches, Wishbone regs
//
// Overview of operation
// - Mode jumper selects program or record encoding
// - Program mode: ASCII 0-9 give 8421 code
// - Program mode: letters B-G give ten-fifteen
// - Record mode: ASCII 0-9 give 8421 code
// - Record mode: space, E, minus give A,F,B
// - Ten four-bit digit positions, filled one-by-one
// - Print reset forces position counter to zero
// - Advance pulse increments position counter by one
// - Ten exclusive selects, pulse one cycle after each accepted strobe cycle
// - Select loads encoded bits into its digit
// - Counter zero loads the leftmost digit
// - Precode pulse loads preset pattern into all
// - Latch output follows data while clock high
// - Latch keeps data after its clock falls
// - Per-bit polarity jumper picks true or complement
// - Digits weighted 8,4,2,1, one output per bit, true or complement set by polarity
// - Invalid character suppresses the data strobe
// - Overflow inhibits further counter advance
// - Precode at I end or clear with K
// - Store command produces the print reset pulse
`timescale 1ns/100ps

`include "abds_defines.svh"

module abds_storage
  import abds_pkg::*;
#(
  parameter int DIGITS = 10,
  parameter int DIGIT_W = 4
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  input wire logic [6:0] ascii_char,
  input wire logic data_strobe_pulse,
  input wire logic store_command_active,
  input wire logic i_cmd_end_of_cycle,
  input wire logic k_cmd_active,
  input wire logic clear_pulse,
  output logic [DIGITS*DIGIT_W-1:0] bcd_out,
  output logic [DIGITS-1:0] digit_select,
  output logic [3:0] digit_position,
  output logic overflow_advance_inhibit,
  output logic invalid_store_inhibit
);

  localparam int TOTAL_W = DIGITS * DIGIT_W;

  // Byte-lane merge used by the ctrl_r and pol_lo_r registers
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Encoder: returns {valid, code}
  function automatic logic [4:0] encode_char(
    input logic [6:0] ch,
    input abds_mode_t mode
  );
    logic [4:0] res;
    logic [6:0] diff;
    res = 5'h00;
    diff = ch - `ABDS_LTR_OFFSET;
    if (ch >= `ABDS_ASC_ZERO && ch <= `ABDS_ASC_NINE)
    begin
      res = {1'b1, ch[3:0]};
    end
    else if (mode == ABDS_PROGRAM_MODE)
    begin
      if (ch >= `ABDS_ASC_LTR_B && ch <= `ABDS_ASC_LTR_G)
      begin
        res = {1'b1, diff[3:0]};
      end
    end
    else
    begin
      case (ch)
        `ABDS_ASC_SPACE: res = {1'b1, `ABDS_BCD_SPACE};
        `ABDS_ASC_LTR_E: res = {1'b1, `ABDS_BCD_E};
        `ABDS_ASC_MINUS: res = {1'b1, `ABDS_BCD_MINUS};
        default: res = 5'h00;
      endcase
    end
    return res;
  endfunction : encode_char

  // Bus and configuration registers
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] pol_lo_r;
  logic [31:0] pol_lo_nxt;
  logic [7:0] pol_hi_r;
  logic [7:0] pol_hi_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic sw_print_reset;
  logic sw_precode;

  // Sequencing state
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic full_r;
  logic full_nxt;
  logic strobe_d_r;
  logic strobe_d_nxt;
  logic accepted_r;
  logic accepted_nxt;
  logic invalid_r;
  logic invalid_nxt;

  // Storage and outputs
  abds_nibble_t digit_r [DIGITS];
  abds_nibble_t digit_nxt [DIGITS];
  logic [TOTAL_W-1:0] out_r;
  logic [TOTAL_W-1:0] out_nxt;
  logic [DIGITS-1:0] sel_r;
  logic [DIGITS-1:0] sel_nxt;

  logic [4:0] enc;
  logic char_valid;
  abds_nibble_t char_code;
  abds_mode_t mode;
  abds_nibble_t preset;
  logic print_reset_pulse;
  logic precode_load_pulse;
  logic strobe_ok;
  logic digit_advance_pulse;
  logic [TOTAL_W-1:0] stored_flat;
  logic [TOTAL_W-1:0] polarity;
  logic bus_write;

  assign mode = abds_mode_t'(ctrl_r[`ABDS_CTRL_MODE_BIT]);
  assign preset = ctrl_r[`ABDS_CTRL_PRESET_LSB +: 4];
  assign polarity = {pol_hi_r, pol_lo_r};
  assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign sw_print_reset = bus_write & (wb_adr_i[7:0] == `ABDS_ADR_CMD)
                          & wb_sel_i[0] & wb_dat_i[`ABDS_CMD_PRINT_RESET_BIT];
  assign sw_precode = bus_write & (wb_adr_i[7:0] == `ABDS_ADR_CMD)
                      & wb_sel_i[0] & wb_dat_i[`ABDS_CMD_PRECODE_BIT];

  assign enc = encode_char(ascii_char, mode);
  assign char_valid = enc[4];
  assign char_code = enc[3:0];

  assign print_reset_pulse = store_command_active | sw_print_reset;
  assign precode_load_pulse = i_cmd_end_of_cycle | (clear_pulse & k_cmd_active)
                              | sw_precode;

  // Code is assumed stable over the strobe; a change mid-strobe would rewrite the digit
  assign strobe_ok = data_strobe_pulse & char_valid & ~full_r
                     & ~print_reset_pulse;
  assign digit_advance_pulse = strobe_d_r & ~data_strobe_pulse & accepted_r;

  // Bus slave: ack one cycle after the request, writes land on the ack edge
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    pol_lo_nxt = pol_lo_r;
    pol_hi_nxt = pol_hi_r;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt = rdat_r;
    if (wb_cyc_i & wb_stb_i & ~ack_r)
    begin
      case (wb_adr_i[7:0])
        `ABDS_ADR_CTRL: rdat_nxt = ctrl_r;
        `ABDS_ADR_POL_LO: rdat_nxt = pol_lo_r;
        `ABDS_ADR_POL_HI: rdat_nxt = {24'h00_0000, pol_hi_r};
        `ABDS_ADR_STATUS: rdat_nxt = {25'h000_0000, data_strobe_pulse, invalid_r,
                                      full_r, cnt_r};
        `ABDS_ADR_DIG_LO: rdat_nxt = stored_flat[31:0];
        `ABDS_ADR_DIG_HI: rdat_nxt = {24'h00_0000, stored_flat[TOTAL_W-1:32]};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
    if (bus_write)
    begin
      case (wb_adr_i[7:0])
        `ABDS_ADR_CTRL:
        begin
          ctrl_nxt = lane_merge(ctrl_r, wb_dat_i, wb_sel_i)
                     & 32'h0000_00F1;
        end
        `ABDS_ADR_POL_LO: pol_lo_nxt = lane_merge(pol_lo_r, wb_dat_i, wb_sel_i);
        `ABDS_ADR_POL_HI:
        begin
          pol_hi_nxt = wb_sel_i[0] ? wb_dat_i[7:0] : pol_hi_r;
        end
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r <= `ABDS_CTRL_RST;
      pol_lo_r <= `ABDS_POL_LO_RST;
      pol_hi_r <= `ABDS_POL_HI_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      pol_lo_r <= pol_lo_nxt;
      pol_hi_r <= pol_hi_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Position counter and strobe tracking
  always_comb
  begin
    cnt_nxt = cnt_r;
    full_nxt = full_r;
    strobe_d_nxt = data_strobe_pulse;
    accepted_nxt = data_strobe_pulse & (accepted_r | strobe_ok);
    invalid_nxt = invalid_r;
    if (data_strobe_pulse & ~char_valid)
    begin
      invalid_nxt = 1'b1;
    end
    else if (data_strobe_pulse)
    begin
      invalid_nxt = 1'b0;
    end
    if (print_reset_pulse)
    begin
      cnt_nxt = 4'h0;
      full_nxt = 1'b0;
      accepted_nxt = 1'b0;
    end
    else if (digit_advance_pulse)
    begin
      // Holding at the last digit keeps an eleventh character out of digit zero
      if (cnt_r == `ABDS_LAST_DIGIT)
      begin
        full_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 4'h0;
      full_r <= 1'b0;
      strobe_d_r <= 1'b0;
      accepted_r <= 1'b0;
      invalid_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      strobe_d_r <= strobe_d_nxt;
      accepted_r <= accepted_nxt;
      invalid_r <= invalid_nxt;
    end
  end

  // Digit selects and latches; a latch opens for every cycle its select is high
  always_comb
  begin
    for (int d = 0; d < DIGITS; d++)
    begin
      sel_nxt[d] = strobe_ok & (cnt_r == 4'(d));
      digit_nxt[d] = digit_r[d];
      if (precode_load_pulse)
      begin
        digit_nxt[d] = preset;
      end
      else if (sel_nxt[d])
      begin
        digit_nxt[d] = char_code;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int d = 0; d < DIGITS; d++)
      begin
        digit_r[d] <= 4'h0;
      end
      sel_r <= '0;
    end
    else
    begin
      digit_r <= digit_nxt;
      sel_r <= sel_nxt;
    end
  end

  // Digit zero is the leftmost group, bits 8,4,2,1 from high to low
  always_comb
  begin
    stored_flat = '0;
    for (int d = 0; d < DIGITS; d++)
    begin
      stored_flat[TOTAL_W-1-d*DIGIT_W -: DIGIT_W] = digit_r[d];
    end
    out_nxt = stored_flat ^ polarity;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_r <= '0;
    end
    else
    begin
      out_r <= out_nxt;
    end
  end

  assign bcd_out = out_r;
  assign digit_select = sel_r;
  assign digit_position = cnt_r;
  assign overflow_advance_inhibit = full_r;
  assign invalid_store_inhibit = invalid_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

endmodule : abds_storage

// ### testbench/abds_checker_assertions.sv
// Port-level assertions for the digit store
`timescale 1ns/100ps
module abds_checker
#(
  parameter int DIGITS = 10,
  parameter int DIGIT_W = 4
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic data_strobe_pulse,
  input wire logic store_command_active,
  input wire logic i_cmd_end_of_cycle,
  input wire logic k_cmd_active,
  input wire logic clear_pulse,
  input wire logic [DIGITS*DIGIT_W-1:0] bcd_out,
  input wire logic [DIGITS-1:0] digit_select,
  input wire logic [3:0] digit_position,
  input wire logic overflow_advance_inhibit,
  input wire logic invalid_store_inhibit
);
  logic pre_t;
  assign pre_t = i_cmd_end_of_cycle || (k_cmd_active && clear_pulse);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence strobe_s;
    data_strobe_pulse && !pre_t && !store_command_active && !(wb_ack_o && wb_we_i);
  endsequence
  sequence accept_s;
    strobe_s ##0 !overflow_advance_inhibit ##1 !invalid_store_inhibit;
  endsequence
  position_reset_a:
    assert property (store_command_active |=> digit_position == 4'h0)
      else $error("position not cleared");
  select_onehot_a:
    assert property ($onehot0(digit_select))
      else $error("several digit selects");
  position_range_a:
    assert property (digit_position <= 4'h9)
      else $error("position out of range");
  full_holds_a:
    assert property (overflow_advance_inhibit |-> digit_position == 4'h9)
      else $error("full without last position");
  advance_once_a:
    assert property (!store_command_active && !$fell(data_strobe_pulse)
      && !(wb_ack_o && wb_we_i) |=> $stable(digit_position)) else $error("stray advance");
  load_select_a:
    assert property (accept_s |-> digit_select == (DIGITS'(1) << $past(digit_position)))
      else $error("wrong digit selected");
  refuse_select_a:
    assert property (strobe_s ##1 invalid_store_inhibit |-> digit_select == '0)
      else $error("invalid character stored");
  hold_digits_a:
    assert property (!data_strobe_pulse && !pre_t && !(wb_ack_o && wb_we_i) |=> ##1 $stable(bcd_out))
      else $error("digits changed without load");
endmodule : abds_checker

bind abds_storage abds_checker #(.DIGITS(DIGITS), .DIGIT_W(DIGIT_W)) abds_checker_inst (
  .mclk(mclk), .nrst(nrst), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .data_strobe_pulse(data_strobe_pulse), .store_command_active(store_command_active),
  .i_cmd_end_of_cycle(i_cmd_end_of_cycle), .k_cmd_active(k_cmd_active),
  .clear_pulse(clear_pulse), .bcd_out(bcd_out), .digit_select(digit_select),
  .digit_position(digit_position), .overflow_advance_inhibit(overflow_advance_inhibit),
  .invalid_store_inhibit(invalid_store_inhibit));

// ### testbench/abds_ctrl_model.sv
// Controller model that presents characters under a data strobe
`timescale 1ns/100ps
module abds_ctrl_model
(
  input wire logic mclk,
  output logic [6:0] ascii_char,
  output logic data_strobe_pulse
);
  initial
  begin
    ascii_char = 7'h7F;
    data_strobe_pulse = 1'b0;
  end
  task automatic send(input logic [6:0] ch, input int len);
    @(posedge mclk);
    ascii_char <= ch;
    data_strobe_pulse <= 1'b1;
    repeat (len) @(posedge mclk);
    data_strobe_pulse <= 1'b0;
    @(posedge mclk);
    // Bits are not held once the strobe is low, so show something different
    ascii_char <= ~ch;
    @(posedge mclk);
  endtask : send
endmodule : abds_ctrl_model

// ### testbench/abds_storage_bench.sv
// Self-checking bench for the ASCII to BCD digit store
`timescale 1ns/100ps
module abds_storage_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic store_command_active = 1'b0;
  logic i_cmd_end_of_cycle = 1'b0;
  logic k_cmd_active = 1'b0;
  logic clear_pulse = 1'b0;
  logic [31:0] wb_dat_o, rd, pol;
  logic wb_ack_o, data_strobe_pulse, overflow_advance_inhibit, invalid_store_inhibit;
  logic [6:0] ascii_char;
  logic [39:0] bcd_out;
  logic [39:0] img = '0;
  logic [9:0] digit_select;
  logic [3:0] digit_position;
  logic [7:0] note;
  logic [7:0] exp_q[$];
  logic [6:0] fix[4] = '{7'h20, 7'h45, 7'h2D, 7'h42};
  int err_total = 0;
  int checks_done = 0;
  int seed = 2928;
  int pos = 0;
  bit watch = 1'b1;
  always #50 mclk = ~mclk;
  abds_ctrl_model abds_ctrl_model_inst (.mclk(mclk), .ascii_char(ascii_char),
    .data_strobe_pulse(data_strobe_pulse));
  abds_storage abds_storage_inst (.mclk(mclk), .nrst(nrst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(4'hF),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .ascii_char(ascii_char),
    .data_strobe_pulse(data_strobe_pulse), .store_command_active(store_command_active),
    .i_cmd_end_of_cycle(i_cmd_end_of_cycle), .k_cmd_active(k_cmd_active),
    .clear_pulse(clear_pulse), .bcd_out(bcd_out), .digit_select(digit_select),
    .digit_position(digit_position), .overflow_advance_inhibit(overflow_advance_inhibit),
    .invalid_store_inhibit(invalid_store_inhibit));
  task automatic finish_test;
    $display("Mismatches %0d in %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    output logic [31:0] q);
    int n;
    n = 0;
    wb_adr_i <= {24'h0, adr};
    wb_dat_i <= dat;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      err_total++;
      finish_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // Bit order is print reset, end of I, K active, clear
  task automatic pulse(input int s);
    @(posedge mclk);
    {store_command_active, i_cmd_end_of_cycle, k_cmd_active, clear_pulse} <= 4'(s);
    @(posedge mclk);
    {store_command_active, i_cmd_end_of_cycle, k_cmd_active, clear_pulse} <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask : pulse
  function automatic logic [4:0] enc(input logic [6:0] c, input logic rec);
    if (c >= 7'h30 && c <= 7'h39) return {1'b1, c[3:0]};
    if (!rec && c >= 7'h42 && c <= 7'h47) return {1'b1, 4'(c - 7'h38)};
    if (rec && c == 7'h20) return 5'h1A;
    if (rec && c == 7'h45) return 5'h1F;
    if (rec && c == 7'h2D) return 5'h1B;
    return 5'h00;
  endfunction : enc
  task automatic put(input logic [6:0] c, input logic rec);
    logic [4:0] e;
    e = enc(c, rec);
    if (e[4] && pos < 10)
    begin
      exp_q.push_back({4'(pos), e[3:0]});
      img[39 - 4 * pos -: 4] = e[3:0];
      pos++;
    end
    abds_ctrl_model_inst.send(c, 1);
    cmp(40'(invalid_store_inhibit), 40'(!e[4]));
  endtask : put
  // The select shows one edge before the registered digit outputs catch up
  always @(posedge mclk)
    if (nrst && watch && digit_select !== 10'h0)
    begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : 8'hFF;
      cmp(40'(digit_select), 40'(10'h1 << note[7:4]));
      @(posedge mclk);
      cmp(40'(bcd_out[39 - 4 * note[7:4] -: 4]), 40'(note[3:0]));
    end
  initial
  begin
    repeat (50000) @(posedge mclk);
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    wb(1'b0, 8'h00, 32'h0, rd);
    cmp(40'(rd), 40'h0);
    wb(1'b0, 8'h40, 32'h0, rd);
    cmp(40'(rd), 40'h0);
    for (int m = 0; m < 2; m++)
    begin
      wb(1'b1, 8'h00, 32'(m), rd);
      foreach (fix[i]) put(fix[i], m[0]);
      repeat (60) put(7'h20 + 7'($random(seed) & 32'h3F), m[0]);
      cmp(40'({overflow_advance_inhibit, digit_position}), 40'(pos > 9 ? 5'h19 : 5'(pos)));
      cmp(bcd_out, img);
      pulse(8);
      cmp(40'(digit_position), 40'h0);
      pos = 0;
    end
    wb(1'b0, 8'h14, 32'h0, rd);
    cmp(40'(rd), 40'(img[31:0]));
    wb(1'b0, 8'h18, 32'h0, rd);
    cmp(40'(rd), 40'(img[39:32]));
    pol = $random(seed);
    wb(1'b1, 8'h04, pol, rd);
    wb(1'b1, 8'h08, 32'h5A, rd);
    repeat (2) @(posedge mclk);
    cmp(bcd_out, img ^ {8'h5A, pol});
    wb(1'b1, 8'h04, 32'h0, rd);
    wb(1'b1, 8'h08, 32'h0, rd);
    watch = 1'b0;
    wb(1'b1, 8'h00, 32'h60, rd);
    pulse(4);
    cmp(bcd_out, {10{4'h6}});
    wb(1'b1, 8'h00, 32'h90, rd);
    pulse(1);
    cmp(bcd_out, {10{4'h6}});
    pulse(3);
    cmp(bcd_out, {10{4'h9}});
    wb(1'b1, 8'h00, 32'h30, rd);
    wb(1'b1, 8'h10, 32'h2, rd);
    repeat (2) @(posedge mclk);
    cmp(bcd_out, {10{4'h3}});
    finish_test();
  end
endmodule : abds_storage_bench
